/* stpc_pkg.sv */
// Constants, modes and register map for the safe stop restart controller.
// Assumes a 100 MHz clock and an APB register slave with 32-bit data.
// Operation
// - Relay removes input level to request stop
// - Stop request kills output drive, motor coasts
// - Internal fault never re-enables drive while stopped
// - Stop status held until operation truly resumes
// - Prevention mode: restore level, then reset
// - Reset from bus, digital input or key
// - Mode defaults to 1; 3 gives auto restart
// - With thermistor, modes 5, 7 and 8 auto restart
// - Auto mode resumes once level is restored
// - Relay ANDs thermistor output with safety sensor
// - Thermistor fitted unlocks modes 4 to 9
// - Modes 1/3 plus thermistor trip: dangerous failure
// - Modes 4/5 plus external stop: dangerous failure
// - Combined installation must configure modes 6 to 9
// - Ramped stop first, drop input after delay
// - Unfinished ramp is abandoned when input drops
// - Relay reset fed by guided contactor contact
// - Reset while level removed keeps drive stopped
// - Prevention stop is alarm, auto stop warning
package stpc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] REG_CFG = 8'h00;
    localparam logic [7:0] REG_CTRL = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_MODE_W = 4;
    localparam int CFG_THERM_BIT = 4;
    localparam int CTRL_RESUME_BIT = 0;
    localparam int CTRL_RUN_BIT = 1;
    localparam int ST_ACTIVE_BIT = 0;
    localparam int ST_ALARM_BIT = 1;
    localparam int ST_WARN_BIT = 2;
    localparam int ST_DANGER_BIT = 3;
    localparam int ST_LEVEL_BIT = 4;
    localparam int ST_DRIVE_BIT = 5;
    localparam int ST_RAMP_BIT = 6;
    localparam logic [3:0] MODE_ALARM = 4'h1;
    localparam logic [3:0] MODE_WARN = 4'h3;
    localparam logic [3:0] MODE_PTC_ALARM = 4'h4;
    localparam logic [3:0] MODE_PTC_WARN = 4'h5;
    localparam logic [3:0] MODE_RELAY_A = 4'h6;
    localparam logic [3:0] MODE_RELAY_W = 4'h7;
    localparam logic [3:0] MODE_RELAY_AW = 4'h8;
    localparam logic [3:0] MODE_RELAY_WA = 4'h9;
    localparam logic [3:0] CFG_MODE_RST = MODE_ALARM;
    localparam logic CFG_THERM_RST = 1'b0;
    localparam logic CTRL_RUN_RST = 1'b0;
    localparam int CLK_MHZ = 100;
    localparam int STOP_RESPONSE_MS = 10;
    localparam int STOP_RESPONSE_CYC = STOP_RESPONSE_MS * 1000 * CLK_MHZ;
    localparam int SAFE_DELAY_MS = 100;
    localparam int SAFE_DELAY_CYC = SAFE_DELAY_MS * 1000 * CLK_MHZ;
    localparam int SYNC_STAGES = 2;
    typedef enum logic {STPC_RUN, STPC_STOPPED} stpc_state_e;
endpackage

/* stpc_link_if.sv */
// Link between the external safety relay and the drive's safe stop input.
// Relay end drives both wires; device end only samples them.
`timescale 1ns/1ps
interface stpc_link_if;
    logic safe_stop_input;
    logic ramped_stop_request;
    modport device (input safe_stop_input, input ramped_stop_request);
    modport relay (output safe_stop_input, output ramped_stop_request);
endinterface

/* stpc_sync.sv */
// Two-flop level synchroniser with a constant reset value.
// Assumes the input may change at any time relative to clk.
`timescale 1ns/1ps
module stpc_sync
    import stpc_pkg::*;
#(
    parameter int STAGES = SYNC_STAGES,
    parameter logic RST_VAL = 1'b0
)(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic din,
    output logic dout
);
    logic [STAGES-1:0] chain;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            chain <= {STAGES{RST_VAL}};
        else
            chain <= {chain[STAGES-2:0], din};
    end

    assign dout = chain[STAGES-1];
endmodule

/* stpc_device.sv */
// Drive-side safe stop controller with an APB register slave.
// Assumes the link wires and local inputs are synchronous to clk.
`timescale 1ns/1ps
module stpc_device
    import stpc_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    stpc_link_if.device link,
    input wire logic reset_din,
    input wire logic reset_key,
    input wire logic thermistor_trip_output,
    input wire logic internal_fault,
    output logic drive_enable,
    output logic ramp_active,
    output logic safe_stop_active,
    output logic safe_stop_alarm_code,
    output logic safe_stop_warning_code,
    output logic dangerous_failure_alarm
);
    stpc_state_e state;
    stpc_state_e next_state;
    logic [CFG_MODE_W-1:0] cfg_mode;
    logic cfg_therm;
    logic ctrl_run;
    logic bus_resume;
    logic level_sync;
    logic therm_sync;
    logic din_q;
    logic key_q;
    logic resume_req;
    logic auto_mode;
    logic stop_now;
    logic danger_now;
    logic wr_access;
    logic rd_setup;
    logic [DATA_W-1:0] status_word;

    // Auto restart decode, used for restart and reporting
    function automatic logic is_auto(input logic [CFG_MODE_W-1:0] m, input logic therm);
        logic r;
        r = 1'b0;
        if (m == MODE_WARN)
            r = 1'b1;
        if (therm && (m == MODE_RELAY_W || m == MODE_RELAY_AW || m == MODE_PTC_WARN))
            r = 1'b1;
        return r;
    endfunction

    // Mode is one usable only without an external relay
    function automatic logic is_ptc_only(input logic [CFG_MODE_W-1:0] m, input logic therm);
        return therm && (m == MODE_PTC_ALARM || m == MODE_PTC_WARN);
    endfunction

    function automatic logic is_plain(input logic [CFG_MODE_W-1:0] m);
        return (m == MODE_ALARM) || (m == MODE_WARN);
    endfunction

    // Restore path and status bit; stop path uses the wire directly
    stpc_sync #(.STAGES(SYNC_STAGES), .RST_VAL(1'b0)) u_level_sync
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .din(link.safe_stop_input),
        .dout(level_sync)
    );

    stpc_sync #(.STAGES(SYNC_STAGES), .RST_VAL(1'b1)) u_therm_sync
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .din(thermistor_trip_output),
        .dout(therm_sync)
    );

    assign wr_access = psel && penable && pwrite;
    assign rd_setup = psel && !penable;
    assign auto_mode = is_auto(cfg_mode, cfg_therm);
    // Level low means stop, independent of mode
    assign stop_now = !link.safe_stop_input;

    // Misconfiguration: wrong source tripped the input
    always_comb
    begin
        danger_now = 1'b0;
        if (is_plain(cfg_mode) && !therm_sync)
            danger_now = 1'b1;
        if (is_ptc_only(cfg_mode, cfg_therm) && stop_now && therm_sync)
            danger_now = 1'b1;
    end

    // Reset edges from the digital input and the key
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            din_q <= 1'b0;
            key_q <= 1'b0;
        end
        else
        begin
            din_q <= reset_din;
            key_q <= reset_key;
        end
    end

    assign resume_req = bus_resume || (reset_din && !din_q) || (reset_key && !key_q);

    always_comb
    begin
        next_state = state;
        unique case (state)
            STPC_RUN:
            begin
                if (stop_now || danger_now)
                    next_state = STPC_STOPPED;
            end
            STPC_STOPPED:
            begin
                // Resume only with restored level and no hazard
                if (level_sync && !stop_now && !dangerous_failure_alarm && !danger_now)
                begin
                    if (auto_mode)
                        next_state = STPC_RUN;
                    else if (resume_req)
                        next_state = STPC_RUN;
                end
                else if (dangerous_failure_alarm && level_sync && !stop_now && resume_req
                    && !danger_now)
                    next_state = STPC_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            state <= STPC_RUN;
        else
            state <= next_state;
    end

    // Output stage gate, no restart from a fault while stopped
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            drive_enable <= 1'b0;
        else
            drive_enable <= (next_state == STPC_RUN) && !stop_now && ctrl_run
                && !internal_fault;
    end

    // Ramp follows the relay request until the input drops
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            ramp_active <= 1'b0;
        else
            ramp_active <= link.ramped_stop_request && (next_state == STPC_RUN)
                && !stop_now;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            safe_stop_active <= 1'b0;
        else
            safe_stop_active <= (next_state == STPC_STOPPED);
    end

    // Report kind chosen at stop entry and held until resume
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            safe_stop_alarm_code <= 1'b0;
            safe_stop_warning_code <= 1'b0;
        end
        else if (next_state == STPC_RUN)
        begin
            safe_stop_alarm_code <= 1'b0;
            safe_stop_warning_code <= 1'b0;
        end
        else if (state == STPC_RUN)
        begin
            safe_stop_alarm_code <= !auto_mode;
            safe_stop_warning_code <= auto_mode;
        end
    end

    // Set wins over the resume that would clear it
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            dangerous_failure_alarm <= 1'b0;
        else if (danger_now)
            dangerous_failure_alarm <= 1'b1;
        else if (next_state == STPC_RUN)
            dangerous_failure_alarm <= 1'b0;
    end

    // Configuration register
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cfg_mode <= CFG_MODE_RST;
            cfg_therm <= CFG_THERM_RST;
        end
        else if (wr_access && paddr == REG_CFG)
        begin
            cfg_mode <= pwdata[CFG_MODE_LSB +: CFG_MODE_W];
            cfg_therm <= pwdata[CFG_THERM_BIT];
        end
    end

    // Control register; resume bit is a one-cycle pulse
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctrl_run <= CTRL_RUN_RST;
            bus_resume <= 1'b0;
        end
        else
        begin
            bus_resume <= wr_access && paddr == REG_CTRL && pwdata[CTRL_RESUME_BIT];
            if (wr_access && paddr == REG_CTRL)
                ctrl_run <= pwdata[CTRL_RUN_BIT];
        end
    end

    always_comb
    begin
        status_word = '0;
        status_word[ST_ACTIVE_BIT] = safe_stop_active;
        status_word[ST_ALARM_BIT] = safe_stop_alarm_code;
        status_word[ST_WARN_BIT] = safe_stop_warning_code;
        status_word[ST_DANGER_BIT] = dangerous_failure_alarm;
        status_word[ST_LEVEL_BIT] = level_sync;
        status_word[ST_DRIVE_BIT] = drive_enable;
        status_word[ST_RAMP_BIT] = ramp_active;
    end

    // Read data and error prepared in the setup cycle
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            prdata <= '0;
            pslverr <= 1'b0;
        end
        else if (rd_setup)
        begin
            pslverr <= !(paddr == REG_CFG || paddr == REG_CTRL || paddr == REG_STATUS)
                || (pwrite && paddr == REG_STATUS);
            prdata <= '0;
            if (!pwrite)
            begin
                if (paddr == REG_CFG)
                    prdata <= {{(DATA_W-CFG_MODE_W-1){1'b0}}, cfg_therm, cfg_mode};
                else if (paddr == REG_CTRL)
                    prdata <= {{(DATA_W-2){1'b0}}, ctrl_run, 1'b0};
                else if (paddr == REG_STATUS)
                    prdata <= status_word;
            end
        end
    end

    // Zero wait states once out of reset
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            pready <= 1'b0;
        else
            pready <= 1'b1;
    end
endmodule

/* stpc_relay.sv */
// External safety relay end: AND logic, ramped stop delay, guided feedback.
// Assumes all user inputs are synchronous to clk.
`timescale 1ns/1ps
module stpc_relay
    import stpc_pkg::*;
#(
    parameter int SAFE_DELAY = SAFE_DELAY_CYC
)(
    input wire logic clk,
    input wire logic sys_rst,
    stpc_link_if.relay link,
    input wire logic sensor_ok,
    input wire logic thermistor_trip_output,
    input wire logic relay_reset,
    input wire logic contactor_aux_closed,
    input wire logic use_ramped_stop,
    output logic contactor_drive
);
    logic enabled;
    logic safety_ok;
    logic [31:0] delay_cnt;
    logic delay_run;

    // Both the thermistor card and the sensor must be healthy
    assign safety_ok = sensor_ok && thermistor_trip_output;

    // Enable needs reset with contactor proven dropped out
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            enabled <= 1'b0;
        // Sensor drop in ramped mode waits for the safe delay
        else if (!thermistor_trip_output || (!sensor_ok && !use_ramped_stop))
            enabled <= 1'b0;
        else if (delay_run && delay_cnt == 32'h0000_0000)
            enabled <= 1'b0;
        else if (!enabled && safety_ok && relay_reset && contactor_aux_closed && !delay_run)
            enabled <= 1'b1;
    end

    // Ramped stop: request ramp, wait, then drop the input
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            delay_run <= 1'b0;
            delay_cnt <= 32'h0000_0000;
        end
        else if (!enabled)
            delay_run <= 1'b0;
        else if (!delay_run && use_ramped_stop && !sensor_ok)
        begin
            delay_run <= 1'b1;
            delay_cnt <= 32'(SAFE_DELAY - 1);
        end
        else if (delay_run && delay_cnt != 32'h0000_0000)
            delay_cnt <= delay_cnt - 32'h0000_0001;
    end

    // Ramped mode holds off the immediate drop
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            link.safe_stop_input <= 1'b0;
            link.ramped_stop_request <= 1'b0;
            contactor_drive <= 1'b0;
        end
        else
        begin
            link.safe_stop_input <= enabled && thermistor_trip_output
                && (sensor_ok || use_ramped_stop);
            link.ramped_stop_request <= enabled && delay_run;
            contactor_drive <= enabled && (safety_ok || delay_run);
        end
    end
endmodule

/* stpc_link_chk.sv */
// Checker for the relay-to-device link and the device's stop outputs.
// Instantiated beside the link interface; one clock, reset active high.
`timescale 1ns/1ps
module stpc_link_chk
    import stpc_pkg::*;
#(
    parameter int SAFE_DELAY = 20
)(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic safe_stop_input,
    input wire logic ramped_stop_request,
    input wire logic sensor_ok,
    input wire logic use_ramped_stop,
    input wire logic thermistor_trip_output,
    input wire logic internal_fault,
    input wire logic drive_enable,
    input wire logic ramp_active,
    input wire logic safe_stop_active,
    input wire logic safe_stop_alarm_code,
    input wire logic safe_stop_warning_code,
    input wire logic dangerous_failure_alarm
);
    localparam int DROP_MAX = SAFE_DELAY + 4;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    AST_STOP_DRIVE: assert property (!safe_stop_input |=> !drive_enable)
        else $error("drive on after stop request");
    AST_STOP_FLAG: assert property (!safe_stop_input |=> safe_stop_active)
        else $error("stop status missing");
    AST_FAULT_OFF: assert property (internal_fault |=> !drive_enable)
        else $error("drive on with internal fault");
    AST_NO_DRIVE_STOPPED: assert property (safe_stop_active |-> !drive_enable)
        else $error("drive on while stopped");
    AST_ONE_CODE: assert property (!(safe_stop_alarm_code && safe_stop_warning_code))
        else $error("alarm and warning together");
    AST_SYNC_RESTORE: assert property ($rose(safe_stop_input) |-> !drive_enable ##1 !drive_enable)
        else $error("restore not synchronised");
    AST_RAMP_HOLD: assert property ($rose(ramped_stop_request) |-> safe_stop_input [*8])
        else $error("input dropped early in ramped stop");
    AST_RAMP_DROP: assert property ($rose(ramped_stop_request) |-> ##[1:DROP_MAX] !safe_stop_input)
        else $error("input not dropped after safe delay");
    AST_RAMP_ABANDON: assert property (!safe_stop_input |=> !ramp_active)
        else $error("ramp kept after input drop");
    AST_RELAY_AND: assert property ((!thermistor_trip_output || (!sensor_ok && !use_ramped_stop))
        |-> ##[1:2] !safe_stop_input)
        else $error("relay kept input high");

    cover property ($rose(dangerous_failure_alarm));
    cover property ($fell(safe_stop_active));
    cover property ($rose(ramped_stop_request));
    cover property ($rose(safe_stop_warning_code));
endmodule

/* stpc_tb.sv */
// Testbench joining device and relay ends across the link interface.
// Drives APB and user inputs at rising edges; checks settled outputs.
`timescale 1ns/1ps
module stpc_tb
    import stpc_pkg::*;
();
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic [DATA_W-1:0] pwdata = 32'h0;
    logic [DATA_W-1:0] prdata;
    logic pready, pslverr, contactor_drive;
    logic drive_enable, ramp_active, safe_stop_active;
    logic safe_stop_alarm_code, safe_stop_warning_code, dangerous_failure_alarm;
    logic reset_din = 1'b0, reset_key = 1'b0, therm_ok = 1'b1, internal_fault = 1'b0;
    logic sensor_ok = 1'b0, relay_reset = 1'b0, aux_closed = 1'b0, use_ramped = 1'b0;
    logic err;
    logic [31:0] d;
    logic [31:0] auto_cfg [3] = '{32'h3, 32'h17, 32'h18};
    logic [31:0] ptc_cfg [2] = '{32'h14, 32'h15};
    logic [31:0] combo_cfg [2] = '{32'h16, 32'h19};
    int errors = 0;
    int comparisons = 0;

    stpc_link_if link();
    stpc_device u_stpc_device (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link), .reset_din(reset_din), .reset_key(reset_key),
        .thermistor_trip_output(therm_ok), .internal_fault(internal_fault),
        .drive_enable(drive_enable), .ramp_active(ramp_active),
        .safe_stop_active(safe_stop_active), .safe_stop_alarm_code(safe_stop_alarm_code),
        .safe_stop_warning_code(safe_stop_warning_code),
        .dangerous_failure_alarm(dangerous_failure_alarm));
    stpc_relay #(.SAFE_DELAY(20)) u_stpc_relay (.clk(clk), .sys_rst(sys_rst), .link(link),
        .sensor_ok(sensor_ok), .thermistor_trip_output(therm_ok), .relay_reset(relay_reset),
        .contactor_aux_closed(aux_closed), .use_ramped_stop(use_ramped),
        .contactor_drive(contactor_drive));
    stpc_link_chk #(.SAFE_DELAY(20)) u_stpc_link_chk (.clk(clk), .sys_rst(sys_rst),
        .safe_stop_input(link.safe_stop_input), .ramped_stop_request(link.ramped_stop_request),
        .sensor_ok(sensor_ok), .use_ramped_stop(use_ramped), .thermistor_trip_output(therm_ok),
        .internal_fault(internal_fault), .drive_enable(drive_enable), .ramp_active(ramp_active),
        .safe_stop_active(safe_stop_active), .safe_stop_alarm_code(safe_stop_alarm_code),
        .safe_stop_warning_code(safe_stop_warning_code),
        .dangerous_failure_alarm(dangerous_failure_alarm));

    initial
    begin
        forever #5 clk = ~clk;
    end

    task step(input int n);
        repeat (n) @(posedge clk);
    endtask

    task check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Bits: dangerous, drive, active, alarm, warning
    task flags(input logic [4:0] e, input logic [4:0] m = 5'h1F);
        @(negedge clk);
        check({27'h0, m & {dangerous_failure_alarm, drive_enable, safe_stop_active,
            safe_stop_alarm_code, safe_stop_warning_code}}, {27'h0, m & e});
    endtask

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        d = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task stop;
        @(posedge clk);
        sensor_ok <= 1'b0;
        step(5);
    endtask

    task restart;
        @(posedge clk);
        sensor_ok <= 1'b1;
        therm_ok <= 1'b1;
        relay_reset <= 1'b1;
        @(posedge clk);
        relay_reset <= 1'b0;
        step(8);
    endtask

    // Resume source: 0 bus, 1 digital input, 2 key
    task resume(input int src);
        if (src == 0)
            apb(1'b1, REG_CTRL, 32'h3);
        else
        begin
            @(posedge clk);
            if (src == 1)
                reset_din <= 1'b1;
            else
                reset_key <= 1'b1;
            step(2);
            reset_din <= 1'b0;
            reset_key <= 1'b0;
        end
        step(3);
    endtask

    task results;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        repeat (6000) @(posedge clk);
        errors++;
        results();
    end

    initial
    begin
        step(16);
        sys_rst <= 1'b0;
        apb(1'b0, REG_CFG, 32'h0);
        check(d, {27'h0, CFG_THERM_RST, CFG_MODE_RST});
        apb(1'b0, 8'h0C, 32'h0);
        check({d[30:0], err}, 32'h1);
        apb(1'b1, REG_STATUS, 32'h0);
        check({31'h0, err}, 32'h1);
        // Contactor not proven: relay must refuse its reset
        @(posedge clk);
        sensor_ok <= 1'b1;
        relay_reset <= 1'b1;
        @(posedge clk);
        relay_reset <= 1'b0;
        step(4);
        @(negedge clk);
        check({31'h0, link.safe_stop_input}, 32'h0);
        check({31'h0, contactor_drive}, 32'h0);
        @(posedge clk);
        aux_closed <= 1'b1;
        restart();
        resume(0);
        flags(5'b01000);
        check({31'h0, contactor_drive}, 32'h1);
        apb(1'b0, REG_STATUS, 32'h0);
        check(d & 32'h7F, 32'h30);
        for (int s = 0; s < 3; s++)
        begin
            stop();
            flags(5'b00110);
            check({31'h0, contactor_drive}, 32'h0);
            resume(s);
            flags(5'b00110);
            restart();
            flags(5'b00110);
            resume(s);
            flags(5'b01000);
        end
        @(posedge clk);
        internal_fault <= 1'b1;
        step(2);
        flags(5'b00000);
        @(posedge clk);
        internal_fault <= 1'b0;
        step(2);
        flags(5'b01000);
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b1, REG_CFG, auto_cfg[i]);
            stop();
            flags(5'b00101);
            restart();
            flags(5'b01000);
        end
        apb(1'b1, REG_CFG, 32'h1);
        @(posedge clk);
        use_ramped <= 1'b1;
        stop();
        @(negedge clk);
        check({31'h0, ramp_active}, 32'h1);
        step(30);
        @(negedge clk);
        check({31'h0, ramp_active}, 32'h0);
        flags(5'b00110);
        @(posedge clk);
        use_ramped <= 1'b0;
        restart();
        resume(0);
        @(posedge clk);
        therm_ok <= 1'b0;
        step(5);
        flags(5'b10000, 5'b11000);
        restart();
        flags(5'b10000, 5'b11000);
        resume(0);
        flags(5'b01000);
        for (int i = 0; i < 2; i++)
        begin
            apb(1'b1, REG_CFG, ptc_cfg[i]);
            stop();
            flags(5'b10000, 5'b11000);
            restart();
            flags(5'b10000, 5'b11000);
            resume(0);
            flags(5'b01000);
        end
        for (int i = 0; i < 2; i++)
        begin
            apb(1'b1, REG_CFG, combo_cfg[i]);
            stop();
            flags(5'b00110);
            restart();
            flags(5'b00110);
            resume(0);
            flags(5'b01000);
        end
        results();
    end
endmodule
